// [scc_pkg.sv]
// Package with constants, types and carriers of the synthesizer channel configuration block
//
// Operation
// - Synthesizer runs only in prepare, transmit, receive
// - Off to prepare: ready flag after lock
// - Commit in prepare retunes, ready on lock
// - Lock loss raises error flag, no state change
// - Lock regained on its own raises ready
// - Off and back forces a fresh tuning run
// - Lock condition readable in a status bit
// - Mode register write applies staged values
// - Scheme 0: base plus index times spacing
// - Base is 16 bits, two bytes
// - Index is 9 bits, top bit in mode
// - Spacing is 8 bits, 25 kHz units
// - Band offset zero or 1.5 GHz
// - Scheme 1: 24-bit word, sub-GHz only
// - Scheme 2: 24-bit word, sub-GHz only
// - Scheme 3: 24-bit word, 2.4 GHz only
// - Base resets to 0x8CF8
// - Mode register layout, zero reset
// - Lock bit reads one while locked
package scc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SPACING = 8'h00;    // Channel spacing
  localparam logic [7:0] ADDR_BASE_LOW = 8'h01;   // Base frequency low byte
  localparam logic [7:0] ADDR_BASE_HIGH = 8'h02;  // Base frequency high byte
  localparam logic [7:0] ADDR_INDEX_LOW = 8'h03;  // Channel index low byte
  localparam logic [7:0] ADDR_MODE = 8'h04;       // Channel mode, commits on write
  localparam logic [7:0] ADDR_STATUS = 8'h05;     // Lock status

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_SCHEME_MSB = 7;  // Scheme select top bit
  localparam int MODE_SCHEME_LSB = 6;  // Scheme select low bit
  localparam int MODE_TOP_BIT = 0;     // Channel index top bit
  localparam int STATUS_LOCK_BIT = 1;  // Lock status bit

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SPACING = 8'h08;
  localparam logic [7:0] RST_BASE_LOW = 8'hF8;
  localparam logic [7:0] RST_BASE_HIGH = 8'h8C;
  localparam logic [7:0] RST_INDEX_LOW = 8'h00;
  localparam logic [1:0] RST_SCHEME = 2'h0;
  localparam logic RST_TOP_BIT = 1'b0;

  // ----------------------------------------------------------------
  // Frequency figures
  // ----------------------------------------------------------------
  localparam int STEP_KHZ = 25;             // Resolution of the default scheme
  localparam int OFFSET_2G4_KHZ = 1500000;  // Band offset of the 2.4 GHz radio
  localparam logic [17:0] OFFSET_2G4_STEPS = 18'(OFFSET_2G4_KHZ / STEP_KHZ);

  // Cycles after a tuning start before the lock input is trusted
  localparam logic [2:0] TUNE_GUARD_CYCLES = 3'h4;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCHEME_IEEE = 2'h0,
    SCHEME_FINE_LOW = 2'h1,
    SCHEME_FINE_MID = 2'h2,
    SCHEME_FINE_2G4 = 2'h3
  } scc_scheme_t;

  typedef enum logic [2:0] {
    TRX_OFF = 3'h0,
    TRX_PREP = 3'h1,
    TRX_TX = 3'h2,
    TRX_RX = 3'h3,
    TRX_SLEEP = 3'h4
  } scc_trx_state_t;

  typedef enum logic [1:0] {
    PLL_IDLE = 2'h0,
    PLL_TUNE = 2'h1,
    PLL_LOCKED = 2'h2,
    PLL_UNLOCKED = 2'h3
  } scc_pll_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scc_bus_req_t;

  typedef struct packed {
    logic [7:0] spacing;
    logic [7:0] base_high;
    logic [7:0] base_low;
    logic [7:0] index_low;
    scc_scheme_t scheme;
    logic index_top;
  } scc_chan_cfg_t;

  typedef struct packed {
    scc_scheme_t scheme;
    logic [17:0] freq_steps;
    logic [23:0] fine_word;
  } scc_tune_t;

endpackage : scc_pkg

// [scc_sync2.sv]
// Two-flop synchronizer for the analog lock and settled levels
`timescale 1ns/100ps
`default_nettype none

module scc_sync2 (
  input wire logic ref_clk_i,     // Block clock
  input wire logic reset_i,       // Synchronous reset, active high
  input wire logic [1:0] async_i, // Levels from outside the clock domain
  output logic [1:0] sync_o       // Levels after two flops
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] stage1; // First flop, read only by the second
    logic [1:0] stage2; // Second flop
  } scc_sync_state_t;

  scc_sync_state_t q;
  scc_sync_state_t next_q;

  // Shift the levels one stage per clock
  always_comb begin
    next_q = q;
    next_q.stage1 = async_i;
    next_q.stage2 = q.stage1;
  end

  // Register the state
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sync_o = q.stage2;

endmodule : scc_sync2

`default_nettype wire

// [scc_chan_calc.sv]
// Channel frequency calculation from one channel configuration
`timescale 1ns/100ps
`default_nettype none

module scc_chan_calc #(
  parameter bit IS_2G4 = 1'b0 // High for the 2.4 GHz radio
) (
  input wire scc_pkg::scc_chan_cfg_t cfg_i, // Configuration to evaluate
  output scc_pkg::scc_tune_t tune_o,        // Resulting tuning word
  output logic applies_o                    // Scheme is valid for this radio
);

  logic [8:0] index;
  logic [16:0] product;
  logic [17:0] sum;

  // Index, product and base sum of the default scheme
  always_comb begin
    index = {cfg_i.index_top, cfg_i.index_low};
    product = 17'(index) * 17'(cfg_i.spacing);
    sum = 18'({cfg_i.base_high, cfg_i.base_low}) + 18'(product);
    tune_o.scheme = cfg_i.scheme;
    tune_o.freq_steps = IS_2G4 ? 18'(sum + scc_pkg::OFFSET_2G4_STEPS) : sum;
    tune_o.fine_word = {cfg_i.base_high, cfg_i.base_low, cfg_i.index_low};
  end

  // Whether the scheme is used by this radio
  always_comb begin
    case (cfg_i.scheme)
      scc_pkg::SCHEME_IEEE: applies_o = 1'b1;
      scc_pkg::SCHEME_FINE_LOW: applies_o = !IS_2G4;
      scc_pkg::SCHEME_FINE_MID: applies_o = !IS_2G4;
      scc_pkg::SCHEME_FINE_2G4: applies_o = IS_2G4;
      default: applies_o = 1'b0;
    endcase
  end

endmodule : scc_chan_calc

`default_nettype wire

// [scc_channel_config.sv]
// Channel configuration registers and lock sequencing of one synthesizer
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module scc_channel_config #(
  parameter bit IS_2G4 = 1'b0 // High for the 2.4 GHz radio
) (
  input wire logic ref_clk_i,                      // 20 MHz block clock
  input wire logic reset_i,                        // Synchronous reset, active high
  input wire scc_pkg::scc_bus_req_t bus_i,         // Register access request
  output logic [7:0] rdata_o,                      // Read data, cycle after read
  input wire scc_pkg::scc_trx_state_t trx_state_i, // Transceiver state, same clock
  input wire logic pll_lock_i,                     // Analog lock level, asynchronous
  input wire logic analog_settled_i,               // Analog settled level, asynchronous
  output logic synth_enable_o,                     // Synthesizer powered
  output logic tune_start_o,                       // One-cycle pulse to start tuning
  output scc_pkg::scc_tune_t tune_o,               // Active tuning word
  output logic ready_irq_flag_o,                   // One-cycle ready event
  output logic error_irq_flag_o                    // One-cycle lock loss event
);

  // ----------------------------------------------------------------
  // State of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    scc_pkg::scc_chan_cfg_t shadow;  // Staged register bytes
    scc_pkg::scc_tune_t active;      // Word the synthesizer runs on
    scc_pkg::scc_pll_state_t pll;    // Lock sequencer state
    logic [2:0] guard;               // Cycles left before lock is trusted
    logic [7:0] rdata;               // Read data register
    logic tune_start;                // Tuning start pulse
    logic ready_flag;                // Ready event pulse
    logic error_flag;                // Error event pulse
  } scc_state_t;

  // Values after reset
  localparam scc_pkg::scc_chan_cfg_t RST_CFG = '{
    spacing: scc_pkg::RST_SPACING,
    base_high: scc_pkg::RST_BASE_HIGH,
    base_low: scc_pkg::RST_BASE_LOW,
    index_low: scc_pkg::RST_INDEX_LOW,
    scheme: scc_pkg::SCHEME_IEEE,
    index_top: scc_pkg::RST_TOP_BIT
  };

  scc_state_t q;       // Registered state
  scc_state_t next_q;  // Next state

  // ----------------------------------------------------------------
  // Helper signals
  // ----------------------------------------------------------------
  logic [1:0] analog_sync;                // Lock and settled after sync
  logic lock_s;                           // Synchronized lock
  logic settled_s;                        // Synchronized settled
  scc_pkg::scc_chan_cfg_t candidate;      // Shadow with the mode byte of a write
  scc_pkg::scc_tune_t candidate_tune;     // Word computed from the candidate
  scc_pkg::scc_tune_t reset_tune;         // Word computed from reset values
  logic candidate_applies;                // Candidate scheme valid here
  logic commit;                           // Mode register written this cycle
  logic active_state;                     // Transceiver in a synthesizer state

  // Decide whether a transceiver state needs the synthesizer
  function automatic logic synth_state(input scc_pkg::scc_trx_state_t s);
    case (s)
      scc_pkg::TRX_PREP: synth_state = 1'b1;
      scc_pkg::TRX_TX: synth_state = 1'b1;
      scc_pkg::TRX_RX: synth_state = 1'b1;
      default: synth_state = 1'b0;
    endcase
  endfunction : synth_state

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------

  // Analog levels enter the clock domain here
  scc_sync2 u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .async_i({analog_settled_i, pll_lock_i}),
    .sync_o(analog_sync)
  );

  assign lock_s = analog_sync[0];
  assign settled_s = analog_sync[1];

  // Frequency of the configuration that a commit would apply
  scc_chan_calc #(
    .IS_2G4(IS_2G4)
  ) u_calc (
    .cfg_i(candidate),
    .tune_o(candidate_tune),
    .applies_o(candidate_applies)
  );

  // Frequency of the reset configuration
  scc_chan_calc #(
    .IS_2G4(IS_2G4)
  ) u_calc_reset (
    .cfg_i(RST_CFG),
    .tune_o(reset_tune),
    .applies_o()
  );

  // ----------------------------------------------------------------
  // Commit candidate
  // ----------------------------------------------------------------

  // Staged bytes plus the mode byte carried by a write in this cycle
  always_comb begin
    candidate = q.shadow;
    candidate.scheme = scc_pkg::scc_scheme_t'(
      bus_i.wdata[scc_pkg::MODE_SCHEME_MSB:scc_pkg::MODE_SCHEME_LSB]);
    candidate.index_top = bus_i.wdata[scc_pkg::MODE_TOP_BIT];
    commit = bus_i.wr && (bus_i.addr == scc_pkg::ADDR_MODE);
    active_state = synth_state(trx_state_i);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // Register file, commit and lock sequencing
  always_comb begin
    next_q = q;
    next_q.tune_start = 1'b0;
    next_q.ready_flag = 1'b0;
    next_q.error_flag = 1'b0;
    next_q.rdata = 8'h00;

    // Register writes go to the shadow bytes only
    if (bus_i.wr) begin
      case (bus_i.addr)
        scc_pkg::ADDR_SPACING: begin
          next_q.shadow.spacing = bus_i.wdata;
        end
        scc_pkg::ADDR_BASE_LOW: begin
          next_q.shadow.base_low = bus_i.wdata;
        end
        scc_pkg::ADDR_BASE_HIGH: begin
          next_q.shadow.base_high = bus_i.wdata;
        end
        scc_pkg::ADDR_INDEX_LOW: begin
          next_q.shadow.index_low = bus_i.wdata;
        end
        scc_pkg::ADDR_MODE: begin
          next_q.shadow.scheme = candidate.scheme;
          next_q.shadow.index_top = candidate.index_top;
        end
        default: begin
          // Unmapped or read-only offset: write ignored
        end
      endcase
    end

    // All staged bytes reach the tuning word in one cycle
    if (commit && candidate_applies) begin
      next_q.active = candidate_tune;
    end

    // Register reads, data stands in the next cycle only
    if (bus_i.rd) begin
      case (bus_i.addr)
        scc_pkg::ADDR_SPACING: begin
          next_q.rdata = q.shadow.spacing;
        end
        scc_pkg::ADDR_BASE_LOW: begin
          next_q.rdata = q.shadow.base_low;
        end
        scc_pkg::ADDR_BASE_HIGH: begin
          next_q.rdata = q.shadow.base_high;
        end
        scc_pkg::ADDR_INDEX_LOW: begin
          next_q.rdata = q.shadow.index_low;
        end
        scc_pkg::ADDR_MODE: begin
          next_q.rdata[scc_pkg::MODE_SCHEME_MSB:scc_pkg::MODE_SCHEME_LSB] =
            q.shadow.scheme;
          next_q.rdata[scc_pkg::MODE_TOP_BIT] = q.shadow.index_top;
        end
        scc_pkg::ADDR_STATUS: begin
          next_q.rdata[scc_pkg::STATUS_LOCK_BIT] =
            (q.pll == scc_pkg::PLL_LOCKED);
        end
        default: begin
          // Unmapped offset reads as zero
        end
      endcase
    end

    // Guard countdown after a tuning start
    if (q.guard != 3'h0) begin
      next_q.guard = q.guard - 3'h1;
    end

    // Lock sequencer
    if (!active_state) begin
      // Synthesizer off outside the active states
      next_q.pll = scc_pkg::PLL_IDLE;
      next_q.guard = 3'h0;
    end else begin
      case (q.pll)
        scc_pkg::PLL_IDLE: begin
          // Entry from off: start a fresh tuning run
          next_q.pll = scc_pkg::PLL_TUNE;
          next_q.tune_start = 1'b1;
          next_q.guard = scc_pkg::TUNE_GUARD_CYCLES;
        end
        scc_pkg::PLL_TUNE: begin
          if (commit && candidate_applies) begin
            // New channel during tuning: restart
            next_q.tune_start = 1'b1;
            next_q.guard = scc_pkg::TUNE_GUARD_CYCLES;
          end else if (q.guard == 3'h0 && lock_s && settled_s) begin
            // Locked and settled: report ready
            next_q.pll = scc_pkg::PLL_LOCKED;
            next_q.ready_flag = 1'b1;
          end
        end
        scc_pkg::PLL_LOCKED: begin
          if (commit && candidate_applies) begin
            // Retune on the new channel
            next_q.pll = scc_pkg::PLL_TUNE;
            next_q.tune_start = 1'b1;
            next_q.guard = scc_pkg::TUNE_GUARD_CYCLES;
          end else if (!lock_s) begin
            // Lock lost: error only, transceiver state untouched
            next_q.pll = scc_pkg::PLL_UNLOCKED;
            next_q.error_flag = 1'b1;
          end
        end
        scc_pkg::PLL_UNLOCKED: begin
          if (commit && candidate_applies) begin
            // Retune on the new channel
            next_q.pll = scc_pkg::PLL_TUNE;
            next_q.tune_start = 1'b1;
            next_q.guard = scc_pkg::TUNE_GUARD_CYCLES;
          end else if (lock_s) begin
            // Lock regained without help
            next_q.pll = scc_pkg::PLL_LOCKED;
            next_q.ready_flag = 1'b1;
          end
        end
        default: begin
          next_q.pll = scc_pkg::PLL_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Reset loads the documented register values and the matching word
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q.shadow <= RST_CFG;
      q.active <= reset_tune;
      q.pll <= scc_pkg::PLL_IDLE;
      q.guard <= 3'h0;
      q.rdata <= 8'h00;
      q.tune_start <= 1'b0;
      q.ready_flag <= 1'b0;
      q.error_flag <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = q.rdata;
  assign synth_enable_o = (q.pll != scc_pkg::PLL_IDLE);
  assign tune_start_o = q.tune_start;
  assign tune_o = q.active;
  assign ready_irq_flag_o = q.ready_flag;
  assign error_irq_flag_o = q.error_flag;

endmodule : scc_channel_config

`default_nettype wire

// [scc_channel_config_asserts.sv]
// Port checker of the channel configuration block
`timescale 1ns/100ps
`default_nettype none

module scc_channel_config_asserts #(
  parameter bit IS_2G4 = 1'b0 // High for the 2.4 GHz radio
) (
  input wire logic ref_clk_i, // Block clock
  input wire logic reset_i, // Synchronous reset
  input wire scc_pkg::scc_bus_req_t bus_i, // Register request
  input wire logic [7:0] rdata_o, // Read data
  input wire scc_pkg::scc_trx_state_t trx_state_i, // Transceiver state
  input wire logic pll_lock_i, // Lock level
  input wire logic analog_settled_i, // Settled level
  input wire logic synth_enable_o, // Synthesizer powered
  input wire logic tune_start_o, // Tuning start pulse
  input wire scc_pkg::scc_tune_t tune_o, // Active tuning word
  input wire logic ready_irq_flag_o, // Ready event
  input wire logic error_irq_flag_o // Lock loss event
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic active; // State that runs the synthesizer
  logic mode_wr; // Commit write
  assign active = trx_state_i inside {scc_pkg::TRX_PREP, scc_pkg::TRX_TX, scc_pkg::TRX_RX};
  assign mode_wr = bus_i.wr && (bus_i.addr == scc_pkg::ADDR_MODE);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_mode_layout; // Unused mode bits read zero
    bus_i.rd && bus_i.addr == scc_pkg::ADDR_MODE |=> rdata_o[5:1] == 5'h00;
  endproperty
  a_mode_layout: assert property (p_mode_layout) else $error("mode spare bits set");
  property p_status_layout; // Only the lock bit, and only while powered
    bus_i.rd && bus_i.addr == scc_pkg::ADDR_STATUS
      |=> (rdata_o & 8'hFD) == 8'h00 && (!rdata_o[1] || $past(synth_enable_o));
  endproperty
  a_status_layout: assert property (p_status_layout) else $error("bad status read");
  property p_tune_hold; // Tuning word moves only on commit
    !$past(mode_wr) |-> $stable(tune_o);
  endproperty
  a_tune_hold: assert property (p_tune_hold) else $error("tuning word moved");
  property p_foreign; // Scheme 3 on the sub-GHz radio, or scheme 1 on the 2.4 GHz radio, has no effect
    mode_wr && bus_i.wdata[7:6] == (IS_2G4 ? 2'h1 : 2'h3) |=> $stable(tune_o) && !tune_start_o;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign scheme applied");
  property p_commit_retune; // Commit while running retunes
    mode_wr && synth_enable_o && active && bus_i.wdata[7:6] == 2'h0 |=> tune_start_o;
  endproperty
  a_commit_retune: assert property (p_commit_retune) else $error("no retune");
  property p_start_entry; // Entering an active state starts tuning
    !synth_enable_o && active |=> synth_enable_o && tune_start_o;
  endproperty
  a_start_entry: assert property (p_start_entry) else $error("no tuning start");
  property p_stop_exit; // Leaving the active states powers down
    synth_enable_o && !active |=> !synth_enable_o;
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("synth still on");
  property p_ready_guard; // No ready during the guard
    tune_start_o |-> !ready_irq_flag_o [*5];
  endproperty
  a_ready_guard: assert property (p_ready_guard) else $error("ready too early");
  property p_error_cause; // Error only after lock loss, state kept
    error_irq_flag_o |-> !$past(pll_lock_i, 3) && synth_enable_o;
  endproperty
  a_error_cause: assert property (p_error_cause) else $error("error without loss");
  property p_ready_cause; // Ready only after lock and settling
    ready_irq_flag_o |-> $past(pll_lock_i, 3) && $past(analog_settled_i, 3);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without lock");
endmodule : scc_channel_config_asserts

bind scc_channel_config scc_channel_config_asserts #(.IS_2G4(IS_2G4)) scc_asserts_i (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .trx_state_i(trx_state_i), .pll_lock_i(pll_lock_i), .analog_settled_i(analog_settled_i),
  .synth_enable_o(synth_enable_o), .tune_start_o(tune_start_o), .tune_o(tune_o),
  .ready_irq_flag_o(ready_irq_flag_o), .error_irq_flag_o(error_irq_flag_o)
);

`default_nettype wire

// [scc_channel_config_tb_top.sv]
// Self-checking testbench of the channel configuration block
`timescale 1ns/100ps
`default_nettype none

module scc_channel_config_tb_top;
  // ------------------------------------------------------------
  // Signals, counters and the register table
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr; // Write before the read-back
    logic [7:0] addr; // Offset
    logic [7:0] wdata; // Data written
    logic [7:0] exp; // Value read back
  } scc_row_t;
  logic ref_clk_i = 1'b0; // Block clock
  logic reset_i = 1'b1; // Held at start
  scc_pkg::scc_bus_req_t bus_i = '0; // Register request
  logic [7:0] rdata_o; // Read data
  scc_pkg::scc_trx_state_t trx_state_i = scc_pkg::TRX_OFF; // Transceiver state
  logic pll_lock_i = 1'b0; // Lock level
  logic analog_settled_i = 1'b0; // Settled level
  logic synth_enable_o, tune_start_o, ready_irq_flag_o, error_irq_flag_o; // Outputs
  scc_pkg::scc_tune_t tune_o; // Tuning word
  logic [2:0] flags; // Start, error and ready pulses
  logic [7:0] rd_val; // Last read data
  logic seen; // Pulse found
  int fail_count = 0;
  int samples_checked = 0;
  // Reset values first, then staging writes, a read-only and an unmapped place
  localparam scc_row_t ROWS [12] = '{
    '{1'b0, 8'h00, 8'h00, 8'h08}, '{1'b0, 8'h01, 8'h00, 8'hF8}, '{1'b0, 8'h02, 8'h00, 8'h8C},
    '{1'b0, 8'h03, 8'h00, 8'h00}, '{1'b0, 8'h04, 8'h00, 8'h00}, '{1'b0, 8'h05, 8'h00, 8'h00},
    '{1'b1, 8'h00, 8'h30, 8'h30}, '{1'b1, 8'h01, 8'hF1, 8'hF1}, '{1'b1, 8'h02, 8'h86, 8'h86},
    '{1'b1, 8'h03, 8'h02, 8'h02}, '{1'b1, 8'h05, 8'hFF, 8'h00}, '{1'b1, 8'h07, 8'h55, 8'h00}
  };
  assign flags = {tune_start_o, error_irq_flag_o, ready_irq_flag_o};

  // Clock, 50 ns period
  always #25 ref_clk_i = ~ref_clk_i;

  scc_channel_config #(.IS_2G4(1'b0)) scc_channel_config_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .trx_state_i(trx_state_i), .pll_lock_i(pll_lock_i), .analog_settled_i(analog_settled_i),
    .synth_enable_o(synth_enable_o), .tune_start_o(tune_start_o), .tune_o(tune_o),
    .ready_irq_flag_o(ready_irq_flag_o), .error_irq_flag_o(error_irq_flag_o)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // One-cycle write, returns just after the taking edge
  task automatic bus_wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk_i);
    bus_i <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    bus_i.wr <= 1'b0;
    #1;
  endtask : bus_wr

  // One-cycle read, data taken in the following cycle
  task automatic bus_rd(input logic [7:0] addr);
    @(posedge ref_clk_i);
    bus_i <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    bus_i.rd <= 1'b0;
    #1;
    rd_val = rdata_o;
  endtask : bus_rd

  // Bounded wait for one of the pulses
  task automatic wait_flag(input int which);
    seen = 1'b0;
    for (int n = 0; n < 20 && !seen; n++) begin
      @(posedge ref_clk_i);
      #1;
      seen = flags[which];
    end
  endtask : wait_flag

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) begin
        bus_wr(ROWS[i].addr, ROWS[i].wdata);
      end
      bus_rd(ROWS[i].addr);
      check(rd_val, ROWS[i].exp);
    end
    check(tune_o, {2'h0, 18'h08CF8, 24'h8CF800});
    bus_wr(scc_pkg::ADDR_MODE, 8'h3F);
    check(tune_o, {2'h0, 18'h0B751, 24'h86F102});
    bus_rd(scc_pkg::ADDR_MODE);
    check(rd_val, 8'h01);
    for (int s = 1; s < 4; s++) begin
      bus_wr(scc_pkg::ADDR_MODE, {2'(s), 6'h00});
      check(tune_o, {(s == 3) ? 2'h2 : 2'(s), 18'h08751, 24'h86F102});
      bus_rd(scc_pkg::ADDR_MODE);
      check(rd_val, {2'(s), 6'h00});
    end
    $display("Register tests done");
    // Lock sequencing in the prepare state
    @(posedge ref_clk_i);
    pll_lock_i <= 1'b1;
    analog_settled_i <= 1'b1;
    trx_state_i <= scc_pkg::TRX_PREP;
    wait_flag(2);
    check(seen, 1'b1);
    wait_flag(0);
    check(seen, 1'b1);
    bus_rd(scc_pkg::ADDR_STATUS);
    check(rd_val, 8'h02);
    @(posedge ref_clk_i);
    pll_lock_i <= 1'b0;
    wait_flag(1);
    check(seen, 1'b1);
    check(synth_enable_o, 1'b1);
    bus_rd(scc_pkg::ADDR_STATUS);
    check(rd_val, 8'h00);
    @(posedge ref_clk_i);
    pll_lock_i <= 1'b1;
    wait_flag(0);
    check(seen, 1'b1);
    bus_wr(scc_pkg::ADDR_MODE, 8'h00);
    check(tune_start_o, 1'b1);
    wait_flag(0);
    check(seen, 1'b1);
    $display("Prepare state tests done");
    // Off and back into transmit and receive
    for (int k = 2; k < 5; k++) begin
      @(posedge ref_clk_i);
      trx_state_i <= (k == 2) ? scc_pkg::TRX_OFF : scc_pkg::TRX_SLEEP;
      repeat (2) @(posedge ref_clk_i);
      #1;
      check(synth_enable_o, 1'b0);
      if (k < 4) begin
        @(posedge ref_clk_i);
        trx_state_i <= scc_pkg::scc_trx_state_t'(k);
        wait_flag(2);
        check(seen, 1'b1);
        wait_flag(0);
        check(seen, 1'b1);
      end
    end
    $display("Transmit and receive tests done");
    // Reset in mid-run brings back the reset word and mode byte
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    #1;
    check(tune_o, {2'h0, 18'h08CF8, 24'h8CF800});
    check(synth_enable_o, 1'b0);
    bus_rd(scc_pkg::ADDR_MODE);
    check(rd_val, 8'h00);
    $display("Reset tests done");
    conclude();
  end

  // Watchdog at 2000 cycles, far beyond the 110 cycles the tests need
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule : scc_channel_config_tb_top

`default_nettype wire
